// File: include/ds_cfg_pkg.sv
// constants, types and code maps shared by the channel settings decoder
package ds_cfg_pkg;
    // ==================================================
    // element type codes: object group and sub-type
    localparam logic [7:0] GRP_QAM = 8'h05;
    localparam logic [7:0] GRP_OFDM = 8'h06;
    localparam logic [7:0] SUB_FLIP = 8'h0F;
    localparam logic [7:0] SUB_POWER = 8'h10;
    localparam logic [7:0] SUB_ADMIN = 8'h01;
    localparam logic [7:0] SUB_OWNER = 8'h02;
    localparam logic [7:0] SUB_MUTE = 8'h03;
    localparam logic [7:0] SUB_BASE = 8'h04;
    localparam logic [7:0] SUB_LOW = 8'h05;
    localparam logic [7:0] SUB_HIGH = 8'h06;
    localparam logic [7:0] SUB_COUNT = 8'h07;
    localparam logic [7:0] SUB_PREFIX = 8'h08;
    localparam logic [7:0] SUB_TAPER = 8'h09;
    localparam logic [7:0] SUB_PLC = 8'h0A;
    // ==================================================
    // defined element lengths in bytes
    localparam logic [7:0] LEN_ONE = 8'h01;
    localparam logic [7:0] LEN_TWO = 8'h02;
    localparam logic [7:0] LEN_FOUR = 8'h04;
    localparam logic [7:0] LEN_SIX = 8'h06;
    // ==================================================
    // legal value ranges of enumerated elements
    localparam logic [7:0] BOOL_MAX = 8'h01;
    localparam logic [7:0] ADMIN_MIN = 8'h01;
    localparam logic [7:0] ADMIN_MAX = 8'h04;
    localparam logic [7:0] CODE_MIN = 8'h01;
    localparam logic [7:0] CODE_MAX = 8'h05;
    // ==================================================
    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_QAM = 12'h008;
    localparam logic [11:0] OFS_ADMIN = 12'h00C;
    localparam logic [11:0] OFS_MAC_LO = 12'h010;
    localparam logic [11:0] OFS_MAC_HI = 12'h014;
    localparam logic [11:0] OFS_BASE = 12'h018;
    localparam logic [11:0] OFS_TONES = 12'h01C;
    localparam logic [11:0] OFS_COUNT = 12'h020;
    localparam logic [11:0] OFS_LENS = 12'h024;
    localparam logic [11:0] OFS_PLC = 12'h028;
    // control bit positions
    localparam int CTRL_VIDEO_BIT = 0;
    localparam int CTRL_DROP_BIT = 1;
    localparam int CTRL_CLR_BIT = 2;
    // ==================================================
    // values after reset
    localparam logic RST_VIDEO = 1'b0;
    localparam logic [7:0] RST_ADMIN = 8'h01;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // ==================================================
    // reason of the most recent rejection
    typedef enum logic [1:0] {
        ERR_NONE = 2'b00,
        ERR_LEN = 2'b01,
        ERR_VALUE = 2'b10,
        ERR_DESC = 2'b11
    } err_t;
    // code to guard prefix length in samples
    function automatic logic [10:0] prefix_len(input logic [7:0] code);
        case (code)
            8'h01: prefix_len = 11'd192;
            8'h02: prefix_len = 11'd256;
            8'h03: prefix_len = 11'd512;
            8'h04: prefix_len = 11'd768;
            8'h05: prefix_len = 11'd1024;
            default: prefix_len = 11'd0;
        endcase
    endfunction
    // code to window taper length in samples
    function automatic logic [8:0] taper_len(input logic [7:0] code);
        case (code)
            8'h02: taper_len = 9'd64;
            8'h03: taper_len = 9'd128;
            8'h04: taper_len = 9'd192;
            8'h05: taper_len = 9'd256;
            default: taper_len = 9'd0;
        endcase
    endfunction
endpackage

// File: src/ds_channel_config_tlv_decoder.sv
// channel settings decoder: element and descriptor intake, APB register view
// Contract
// - spectrum flip: 0 upright, 1 inverted, rest reserved
// - spectrum flip applied to video channels only
// - power offset is signed tenths of dBmW
// - admin state 1..4 valid, others reserved
// - store owner MAC, zero when no owner
// - RF mute: 0 transmit, 1 muted, rest reserved
// - four-byte subcarrier zero frequency in hertz
// - two-byte lowest active subcarrier index
// - two-byte highest active subcarrier index
// - two-byte active subcarrier count
// - prefix code 1..5 maps to prefix length
// - window code 1..5 maps to taper length
// - four-byte link channel base frequency hertz
// - settings accepted from elements or descriptor
`timescale 1ns/1ps
module ds_channel_config_tlv_decoder (
    input wire logic I_CLK,
    input wire logic I_RST,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // one element per cycle, value right aligned, first byte highest
    input wire logic I_ELEM_VALID,
    input wire logic [7:0] I_ELEM_GROUP,
    input wire logic [7:0] I_ELEM_SUB,
    input wire logic [7:0] I_ELEM_LEN,
    input wire logic [47:0] I_ELEM_VALUE,
    // channel descriptor message fields
    input wire logic I_DESC_VALID,
    input wire logic [31:0] I_DESC_BASE_FREQ,
    input wire logic [15:0] I_DESC_LOW_TONE,
    input wire logic [15:0] I_DESC_HIGH_TONE,
    input wire logic [15:0] I_DESC_TONE_COUNT,
    input wire logic [7:0] I_DESC_PREFIX_CODE,
    input wire logic [7:0] I_DESC_TAPER_CODE,
    input wire logic [31:0] I_DESC_PLC_FREQ,
    // decoded settings
    output logic O_SPECTRUM_FLIP_FLAG,
    output logic [7:0] O_CHANNEL_POWER_OFFSET,
    output logic [7:0] O_CHANNEL_ADMIN_CONDITION,
    output logic [47:0] O_OWNING_CORE_MAC,
    output logic O_RF_SILENCE,
    output logic [31:0] O_BASE_TONE_FREQUENCY,
    output logic [15:0] O_LOWEST_ACTIVE_TONE,
    output logic [15:0] O_HIGHEST_ACTIVE_TONE,
    output logic [15:0] O_ACTIVE_TONE_COUNT,
    output logic [10:0] O_GUARD_PREFIX_LENGTH,
    output logic [8:0] O_WINDOW_TAPER_LENGTH,
    output logic [31:0] O_LINK_CHANNEL_BASE_FREQUENCY,
    output logic O_ERROR
);
    // ==================================================
    // storage
    logic flip;
    logic video;
    logic owner_present;
    logic err_flag;
    ds_cfg_pkg::err_t err_reason;
    logic [7:0] power;
    logic [7:0] admin;
    logic [47:0] mac;
    logic mute;
    logic [31:0] base_freq;
    logic [15:0] low_tone;
    logic [15:0] high_tone;
    logic [15:0] tone_count;
    logic [10:0] prefix;
    logic [8:0] taper;
    logic [31:0] plc_freq;
    // ==================================================
    // element decode
    logic [7:0] v1;
    logic [7:0] exp_len;
    logic known;
    logic val_ok;
    logic len_bad;
    logic val_bad;
    logic elem_ok;
    logic desc_ok;
    logic desc_bad;
    logic [15:0] key;

    assign v1 = I_ELEM_VALUE[7:0];
    assign key = {I_ELEM_GROUP, I_ELEM_SUB};

    // expected length and value check per element type
    always_comb begin
        known = 1'b1;
        exp_len = ds_cfg_pkg::LEN_ONE;
        val_ok = 1'b1;
        case (key)
            {ds_cfg_pkg::GRP_QAM, ds_cfg_pkg::SUB_FLIP}: begin
                val_ok = (v1 <= ds_cfg_pkg::BOOL_MAX);
            end
            {ds_cfg_pkg::GRP_QAM, ds_cfg_pkg::SUB_POWER}: begin
                val_ok = 1'b1; // every byte is a legal offset
            end
            {ds_cfg_pkg::GRP_OFDM, ds_cfg_pkg::SUB_ADMIN}: begin
                val_ok = (v1 >= ds_cfg_pkg::ADMIN_MIN) && (v1 <= ds_cfg_pkg::ADMIN_MAX);
            end
            {ds_cfg_pkg::GRP_OFDM, ds_cfg_pkg::SUB_OWNER}: begin
                exp_len = ds_cfg_pkg::LEN_SIX;
            end
            {ds_cfg_pkg::GRP_OFDM, ds_cfg_pkg::SUB_MUTE}: begin
                val_ok = (v1 <= ds_cfg_pkg::BOOL_MAX);
            end
            {ds_cfg_pkg::GRP_OFDM, ds_cfg_pkg::SUB_BASE},
            {ds_cfg_pkg::GRP_OFDM, ds_cfg_pkg::SUB_PLC}: begin
                exp_len = ds_cfg_pkg::LEN_FOUR;
            end
            {ds_cfg_pkg::GRP_OFDM, ds_cfg_pkg::SUB_LOW},
            {ds_cfg_pkg::GRP_OFDM, ds_cfg_pkg::SUB_HIGH},
            {ds_cfg_pkg::GRP_OFDM, ds_cfg_pkg::SUB_COUNT}: begin
                exp_len = ds_cfg_pkg::LEN_TWO;
            end
            {ds_cfg_pkg::GRP_OFDM, ds_cfg_pkg::SUB_PREFIX},
            {ds_cfg_pkg::GRP_OFDM, ds_cfg_pkg::SUB_TAPER}: begin
                val_ok = (v1 >= ds_cfg_pkg::CODE_MIN) && (v1 <= ds_cfg_pkg::CODE_MAX);
            end
            default: begin
                known = 1'b0; // other objects belong to other decoders
            end
        endcase
    end

    // length is checked before value, so a short element never reports a value fault
    assign len_bad = I_ELEM_VALID && known && (I_ELEM_LEN != exp_len);
    assign val_bad = I_ELEM_VALID && known && !len_bad && !val_ok;
    assign elem_ok = I_ELEM_VALID && known && !len_bad && val_ok;
    // a descriptor with a reserved code is dropped whole, never half applied
    assign desc_ok = I_DESC_VALID
        && (I_DESC_PREFIX_CODE >= ds_cfg_pkg::CODE_MIN)
        && (I_DESC_PREFIX_CODE <= ds_cfg_pkg::CODE_MAX)
        && (I_DESC_TAPER_CODE >= ds_cfg_pkg::CODE_MIN)
        && (I_DESC_TAPER_CODE <= ds_cfg_pkg::CODE_MAX);
    assign desc_bad = I_DESC_VALID && !desc_ok;

    // ==================================================
    // apb decode
    logic wr_en;
    logic rd_setup;
    logic mapped;
    logic [31:0] rd_mux;

    assign wr_en = I_PSEL && I_PENABLE && I_PWRITE;
    assign rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
    assign O_PREADY = I_PSEL && I_PENABLE; // no wait states: read data is staged at setup
    assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

    // read view and address map
    always_comb begin
        mapped = 1'b1;
        rd_mux = ds_cfg_pkg::RST_WORD;
        case (I_PADDR)
            ds_cfg_pkg::OFS_CTRL: rd_mux = {31'd0, video};
            ds_cfg_pkg::OFS_STATUS: rd_mux = {22'd0, err_reason, 7'd0, err_flag};
            ds_cfg_pkg::OFS_QAM: rd_mux = {16'd0, power, 6'd0, O_SPECTRUM_FLIP_FLAG, flip};
            ds_cfg_pkg::OFS_ADMIN: rd_mux = {15'd0, mute, 7'd0, owner_present, admin};
            ds_cfg_pkg::OFS_MAC_LO: rd_mux = O_OWNING_CORE_MAC[31:0];
            ds_cfg_pkg::OFS_MAC_HI: rd_mux = {16'd0, O_OWNING_CORE_MAC[47:32]};
            ds_cfg_pkg::OFS_BASE: rd_mux = base_freq;
            ds_cfg_pkg::OFS_TONES: rd_mux = {high_tone, low_tone};
            ds_cfg_pkg::OFS_COUNT: rd_mux = {16'd0, tone_count};
            ds_cfg_pkg::OFS_LENS: rd_mux = {7'd0, taper, 5'd0, prefix};
            ds_cfg_pkg::OFS_PLC: rd_mux = plc_freq;
            default: mapped = 1'b0;
        endcase
    end

    // read data staged in the setup cycle, held through the access cycle
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_PRDATA <= ds_cfg_pkg::RST_WORD;
        end else if (rd_setup) begin
            O_PRDATA <= rd_mux;
        end
    end

    // control: channel kind; owner release and error clear sit with their registers
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            video <= ds_cfg_pkg::RST_VIDEO;
        end else if (wr_en && (I_PADDR == ds_cfg_pkg::OFS_CTRL)) begin
            video <= I_PWDATA[ds_cfg_pkg::CTRL_VIDEO_BIT];
        end
    end

    // ==================================================
    // video QAM settings
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            flip <= 1'b0;
            power <= 8'h00;
        end else if (elem_ok && (I_ELEM_GROUP == ds_cfg_pkg::GRP_QAM)) begin
            if (I_ELEM_SUB == ds_cfg_pkg::SUB_FLIP) begin
                flip <= v1[0];
            end else begin
                power <= v1; // two's complement tenths
            end
        end
    end

    // inversion only reaches the output on a video channel
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_SPECTRUM_FLIP_FLAG <= 1'b0;
            O_CHANNEL_POWER_OFFSET <= 8'h00;
        end else begin
            O_SPECTRUM_FLIP_FLAG <= flip && video;
            O_CHANNEL_POWER_OFFSET <= power;
        end
    end

    // ==================================================
    // owner address; a new address wins over a release from software in the same cycle
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            mac <= 48'h0000_0000_0000;
            owner_present <= 1'b0;
        end else if (elem_ok && (key == {ds_cfg_pkg::GRP_OFDM, ds_cfg_pkg::SUB_OWNER})) begin
            mac <= I_ELEM_VALUE;
            owner_present <= 1'b1;
        end else if (wr_en && (I_PADDR == ds_cfg_pkg::OFS_CTRL)
                && I_PWDATA[ds_cfg_pkg::CTRL_DROP_BIT]) begin
            owner_present <= 1'b0;
        end
    end

    // report zeros while no core operates the channel
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_OWNING_CORE_MAC <= 48'h0000_0000_0000;
        end else begin
            O_OWNING_CORE_MAC <= owner_present ? mac : 48'h0000_0000_0000;
        end
    end

    // ==================================================
    // OFDM state and mute
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            admin <= ds_cfg_pkg::RST_ADMIN;
            mute <= 1'b0;
        end else if (elem_ok && (I_ELEM_GROUP == ds_cfg_pkg::GRP_OFDM)) begin
            if (I_ELEM_SUB == ds_cfg_pkg::SUB_ADMIN) begin
                admin <= v1;
            end
            if (I_ELEM_SUB == ds_cfg_pkg::SUB_MUTE) begin
                mute <= v1[0];
            end
        end
    end

    // ==================================================
    // OFDM layout: descriptor first, a same-cycle element then overrides its field
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            base_freq <= ds_cfg_pkg::RST_WORD;
            low_tone <= 16'h0000;
            high_tone <= 16'h0000;
            tone_count <= 16'h0000;
            prefix <= 11'd0;
            taper <= 9'd0;
            plc_freq <= ds_cfg_pkg::RST_WORD;
        end else begin
            if (desc_ok) begin
                base_freq <= I_DESC_BASE_FREQ;
                low_tone <= I_DESC_LOW_TONE;
                high_tone <= I_DESC_HIGH_TONE;
                tone_count <= I_DESC_TONE_COUNT;
                prefix <= ds_cfg_pkg::prefix_len(I_DESC_PREFIX_CODE);
                taper <= ds_cfg_pkg::taper_len(I_DESC_TAPER_CODE);
                plc_freq <= I_DESC_PLC_FREQ;
            end
            if (elem_ok && (I_ELEM_GROUP == ds_cfg_pkg::GRP_OFDM)) begin
                case (I_ELEM_SUB)
                    ds_cfg_pkg::SUB_BASE: base_freq <= I_ELEM_VALUE[31:0];
                    ds_cfg_pkg::SUB_LOW: low_tone <= I_ELEM_VALUE[15:0];
                    ds_cfg_pkg::SUB_HIGH: high_tone <= I_ELEM_VALUE[15:0];
                    ds_cfg_pkg::SUB_COUNT: tone_count <= I_ELEM_VALUE[15:0];
                    ds_cfg_pkg::SUB_PREFIX: prefix <= ds_cfg_pkg::prefix_len(v1);
                    ds_cfg_pkg::SUB_TAPER: taper <= ds_cfg_pkg::taper_len(v1);
                    // grid is the controller's duty; stored as given
                    ds_cfg_pkg::SUB_PLC: plc_freq <= I_ELEM_VALUE[31:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // layout outputs straight from the stored settings
    assign O_CHANNEL_ADMIN_CONDITION = admin;
    assign O_RF_SILENCE = mute;
    assign O_BASE_TONE_FREQUENCY = base_freq;
    assign O_LOWEST_ACTIVE_TONE = low_tone;
    assign O_HIGHEST_ACTIVE_TONE = high_tone;
    assign O_ACTIVE_TONE_COUNT = tone_count;
    assign O_GUARD_PREFIX_LENGTH = prefix;
    assign O_WINDOW_TAPER_LENGTH = taper;
    assign O_LINK_CHANNEL_BASE_FREQUENCY = plc_freq;

    // ==================================================
    // sticky error: a new fault wins over a clear in the same cycle
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            err_flag <= 1'b0;
            err_reason <= ds_cfg_pkg::ERR_NONE;
        end else if (len_bad || val_bad || desc_bad) begin
            err_flag <= 1'b1;
            if (len_bad) begin
                err_reason <= ds_cfg_pkg::ERR_LEN;
            end else if (val_bad) begin
                err_reason <= ds_cfg_pkg::ERR_VALUE;
            end else begin
                err_reason <= ds_cfg_pkg::ERR_DESC;
            end
        end else if (wr_en && (I_PADDR == ds_cfg_pkg::OFS_CTRL)
                && I_PWDATA[ds_cfg_pkg::CTRL_CLR_BIT]) begin
            err_flag <= 1'b0;
            err_reason <= ds_cfg_pkg::ERR_NONE;
        end
    end

    assign O_ERROR = err_flag;
endmodule

// File: tb/ds_cfg_checker_properties.sv
// port checks for the channel settings decoder
`timescale 1ns/1ps
module ds_cfg_checker (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic [11:0] I_PADDR,
    input wire logic I_ELEM_VALID,
    input wire logic [7:0] I_ELEM_GROUP,
    input wire logic [7:0] I_ELEM_SUB,
    input wire logic [7:0] I_ELEM_LEN,
    input wire logic [47:0] I_ELEM_VALUE,
    input wire logic I_DESC_VALID,
    input wire logic [15:0] I_DESC_LOW_TONE,
    input wire logic [7:0] I_DESC_PREFIX_CODE,
    input wire logic [7:0] I_DESC_TAPER_CODE,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic O_SPECTRUM_FLIP_FLAG,
    input wire logic [7:0] O_CHANNEL_POWER_OFFSET,
    input wire logic [7:0] O_CHANNEL_ADMIN_CONDITION,
    input wire logic [47:0] O_OWNING_CORE_MAC,
    input wire logic [15:0] O_LOWEST_ACTIVE_TONE,
    input wire logic [10:0] O_GUARD_PREFIX_LENGTH,
    input wire logic [8:0] O_WINDOW_TAPER_LENGTH,
    input wire logic [31:0] O_BASE_TONE_FREQUENCY,
    input wire logic O_ERROR
);
    // ===
    // helpers
    logic [15:0] ty; // type key
    logic [7:0] v;
    logic ev; // one-byte element
    assign ty = {I_ELEM_GROUP, I_ELEM_SUB};
    assign v = I_ELEM_VALUE[7:0];
    assign ev = I_ELEM_VALID && I_ELEM_LEN == 8'h01;
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    // ===
    // element decoding
    a_prefix_map: assert property (
        ev && ty == 16'h0608 && v == 8'h05 |=> O_GUARD_PREFIX_LENGTH == 11'h400)
        else $error("prefix code 5 unmapped");
    a_taper_map: assert property (
        ev && ty == 16'h0609 && v == 8'h01 |=> O_WINDOW_TAPER_LENGTH == 9'h000)
        else $error("taper code 1 unmapped");
    a_admin_keep: assert property (
        ev && ty == 16'h0601 && (v == 8'h00 || v > 8'h04)
        |=> $stable(O_CHANNEL_ADMIN_CONDITION) ##[0:1] O_ERROR)
        else $error("reserved admin taken");
    a_flip_keep: assert property (
        ev && ty == 16'h050F && v > 8'h01 && !I_PSEL
        |-> ##2 O_SPECTRUM_FLIP_FLAG == $past(O_SPECTRUM_FLIP_FLAG, 2))
        else $error("reserved flip taken");
    a_power_load: assert property (
        ev && ty == 16'h0510 |-> ##2 O_CHANNEL_POWER_OFFSET == $past(v, 2))
        else $error("power not loaded");
    a_mac_load: assert property (
        I_ELEM_VALID && ty == 16'h0602 && I_ELEM_LEN == 8'h06
        |-> ##2 O_OWNING_CORE_MAC == $past(I_ELEM_VALUE, 2))
        else $error("mac not loaded");
    a_len_reject: assert property (
        I_ELEM_VALID && ty == 16'h0605 && I_ELEM_LEN != 8'h02 && !I_DESC_VALID
        |=> $stable(O_LOWEST_ACTIVE_TONE) ##[0:1] O_ERROR)
        else $error("bad length taken");
    // ===
    // descriptor and bus
    a_desc_load: assert property (
        I_DESC_VALID && !I_ELEM_VALID && I_DESC_PREFIX_CODE inside {[8'h01:8'h05]}
        && I_DESC_TAPER_CODE inside {[8'h01:8'h05]}
        |=> O_LOWEST_ACTIVE_TONE == $past(I_DESC_LOW_TONE))
        else $error("descriptor not loaded");
    a_desc_drop: assert property (
        I_DESC_VALID && !I_ELEM_VALID && I_DESC_PREFIX_CODE == 8'h00
        |=> $stable(O_LOWEST_ACTIVE_TONE))
        else $error("bad descriptor taken");
    a_ready_now: assert property (I_PSEL && I_PENABLE |-> O_PREADY)
        else $error("no ready");
    a_slverr_map: assert property (
        I_PSEL && I_PENABLE && I_PADDR > 12'h028 |-> O_PSLVERR && O_PREADY)
        else $error("unmapped not refused");
endmodule
bind ds_channel_config_tlv_decoder ds_cfg_checker chk_u (.*);

// File: tb/ds_cfg_core_model.sv
// controller model that sends configuration elements and descriptors
`timescale 1ns/1ps
module ds_cfg_core_model (
    input wire logic I_CLK,
    output logic I_ELEM_VALID,
    output logic [7:0] I_ELEM_GROUP,
    output logic [7:0] I_ELEM_SUB,
    output logic [7:0] I_ELEM_LEN,
    output logic [47:0] I_ELEM_VALUE,
    output logic I_DESC_VALID,
    output logic [31:0] I_DESC_BASE_FREQ,
    output logic [15:0] I_DESC_LOW_TONE,
    output logic [15:0] I_DESC_HIGH_TONE,
    output logic [15:0] I_DESC_TONE_COUNT,
    output logic [7:0] I_DESC_PREFIX_CODE,
    output logic [7:0] I_DESC_TAPER_CODE,
    output logic [31:0] I_DESC_PLC_FREQ
);
    // idle at time zero
    initial begin
        {I_ELEM_VALID, I_ELEM_GROUP, I_ELEM_SUB, I_ELEM_LEN, I_ELEM_VALUE} = '0;
        {I_DESC_VALID, I_DESC_BASE_FREQ, I_DESC_LOW_TONE, I_DESC_HIGH_TONE} = '0;
        {I_DESC_TONE_COUNT, I_DESC_PREFIX_CODE, I_DESC_TAPER_CODE, I_DESC_PLC_FREQ} = '0;
    end
    // value inverted on release so stale data never matches
    task automatic send_elem(input logic [7:0] g, s, l, input logic [47:0] v);
        {I_ELEM_VALID, I_ELEM_GROUP, I_ELEM_SUB, I_ELEM_LEN, I_ELEM_VALUE} <= {1'b1, g, s, l, v};
        @(posedge I_CLK);
        {I_ELEM_VALID, I_ELEM_VALUE} <= {1'b0, ~v};
    endtask
    // descriptor as second settings source
    task automatic send_desc(input logic [31:0] bf, input logic [15:0] lo, hi, ct,
        input logic [7:0] pc, tc, input logic [31:0] pf);
        {I_DESC_VALID, I_DESC_BASE_FREQ, I_DESC_LOW_TONE, I_DESC_HIGH_TONE} <= {1'b1, bf, lo, hi};
        {I_DESC_TONE_COUNT, I_DESC_PREFIX_CODE, I_DESC_TAPER_CODE, I_DESC_PLC_FREQ} <= {ct, pc, tc, pf};
        @(posedge I_CLK);
        I_DESC_VALID <= 1'b0;
    endtask
endmodule

// File: tb/ds_channel_config_tlv_decoder_tb_top.sv
// self-checking bench for the channel settings decoder
`timescale 1ns/1ps
module ds_channel_config_tlv_decoder_tb_top;
    // ===
    // port-named signals
    logic I_CLK = 1'b0, I_RST = 1'b1, I_PSEL = 1'b0, I_PENABLE = 1'b0, I_PWRITE = 1'b0;
    logic [11:0] I_PADDR = 12'h000;
    logic [31:0] I_PWDATA = 32'h0000_0000;
    logic I_ELEM_VALID, I_DESC_VALID, O_PREADY, O_PSLVERR, O_SPECTRUM_FLIP_FLAG;
    logic [7:0] I_ELEM_GROUP, I_ELEM_SUB, I_ELEM_LEN, I_DESC_PREFIX_CODE, I_DESC_TAPER_CODE;
    logic [47:0] I_ELEM_VALUE, O_OWNING_CORE_MAC;
    logic [31:0] I_DESC_BASE_FREQ, I_DESC_PLC_FREQ, O_PRDATA, O_BASE_TONE_FREQUENCY;
    logic [15:0] I_DESC_LOW_TONE, I_DESC_HIGH_TONE, I_DESC_TONE_COUNT, O_LOWEST_ACTIVE_TONE;
    logic [15:0] O_HIGHEST_ACTIVE_TONE, O_ACTIVE_TONE_COUNT;
    logic [31:0] O_LINK_CHANNEL_BASE_FREQUENCY, rd;
    logic [7:0] O_CHANNEL_POWER_OFFSET, O_CHANNEL_ADMIN_CONDITION;
    logic [10:0] O_GUARD_PREFIX_LENGTH;
    logic [8:0] O_WINDOW_TAPER_LENGTH;
    logic O_RF_SILENCE, O_ERROR, er;
    int n_fail = 0, n_compared = 0, cycles = 0;
    ds_channel_config_tlv_decoder dut_u (.*);
    ds_cfg_core_model core_u (.*);
    // 100 ns period
    always #50 I_CLK = ~I_CLK;
    // hang guard, over thirteen times the run
    always @(posedge I_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            end_of_test;
        end
    end
    // ===
    // shared tasks
    task end_of_test;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task chk(input logic [47:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // apb transfer; idle edges let outputs settle
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA} <= {1'b1, 1'b0, w, a, d};
        @(posedge I_CLK);
        I_PENABLE <= 1'b1;
        @(posedge I_CLK);
        while (O_PREADY !== 1'b1) @(posedge I_CLK);
        rd = O_PRDATA;
        er = O_PSLVERR;
        {I_PSEL, I_PENABLE} <= 2'b00;
        repeat (3) @(posedge I_CLK);
    endtask
    task el(input logic [7:0] g, s, l, input logic [47:0] v);
        core_u.send_elem(g, s, l, v);
        repeat (3) @(posedge I_CLK);
    endtask
    task clr;
        apb(1'b1, ds_cfg_pkg::OFS_CTRL, 32'h0000_0004);
        chk(48'(O_ERROR), 48'h0);
    endtask
    // ===
    // scenarios
    task t_codes;
        logic [10:0] pl [5];
        logic [8:0] tl [5];
        pl = '{11'h0C0, 11'h100, 11'h200, 11'h300, 11'h400};
        tl = '{9'h000, 9'h040, 9'h080, 9'h0C0, 9'h100};
        for (int i = 0; i < 5; i++) begin
            el(8'h06, 8'h08, 8'h01, 48'(i + 1));
            chk(48'(O_GUARD_PREFIX_LENGTH), 48'(pl[i]));
            el(8'h06, 8'h09, 8'h01, 48'(i + 1));
            chk(48'(O_WINDOW_TAPER_LENGTH), 48'(tl[i]));
        end
        el(8'h06, 8'h08, 8'h01, 48'h6);
        el(8'h06, 8'h09, 8'h01, 48'h0);
        chk(48'({O_GUARD_PREFIX_LENGTH, O_WINDOW_TAPER_LENGTH}), 48'h8_0100);
        apb(1'b0, ds_cfg_pkg::OFS_STATUS, 32'h0000_0000);
        chk(48'(rd[9:0]), 48'h201);
        clr;
    endtask
    task t_flip;
        el(8'h05, 8'h0F, 8'h01, 48'h1);
        chk(48'(O_SPECTRUM_FLIP_FLAG), 48'h0);
        apb(1'b1, ds_cfg_pkg::OFS_CTRL, 32'h0000_0001);
        chk(48'(O_SPECTRUM_FLIP_FLAG), 48'h1);
        el(8'h05, 8'h0F, 8'h01, 48'h2);
        chk(48'({O_SPECTRUM_FLIP_FLAG, O_ERROR}), 48'h3);
        el(8'h05, 8'h0F, 8'h01, 48'h0);
        chk(48'(O_SPECTRUM_FLIP_FLAG), 48'h0);
        el(8'h05, 8'h10, 8'h01, 48'hF6);
        el(8'h05, 8'h10, 8'h02, 48'h5);
        chk(48'(O_CHANNEL_POWER_OFFSET), 48'hF6);
        apb(1'b0, ds_cfg_pkg::OFS_QAM, 32'h0000_0000);
        chk(48'(rd[15:0]), 48'hF600);
        clr;
    endtask
    task t_ofdm;
        for (int i = 2; i < 6; i++) begin
            el(8'h06, 8'h01, 8'h01, 48'(i));
            chk(48'(O_CHANNEL_ADMIN_CONDITION), 48'(i < 5 ? i : 4));
        end
        el(8'h06, 8'h03, 8'h01, 48'h1);
        el(8'h06, 8'h03, 8'h01, 48'h2);
        chk(48'(O_RF_SILENCE), 48'h1);
        el(8'h06, 8'h04, 8'h04, 48'h2F8A_BC40);
        el(8'h06, 8'h05, 8'h02, 48'h0094);
        el(8'h06, 8'h06, 8'h02, 48'h0F6B);
        el(8'h06, 8'h07, 8'h02, 48'h0ED8);
        el(8'h06, 8'h0A, 8'h04, 48'h2FAF_0800);
        el(8'h06, 8'h05, 8'h01, 48'h7);
        chk(48'(O_BASE_TONE_FREQUENCY), 48'h2F8A_BC40);
        chk(48'(O_LOWEST_ACTIVE_TONE), 48'h0094);
        chk(48'(O_HIGHEST_ACTIVE_TONE), 48'h0F6B);
        chk(48'(O_ACTIVE_TONE_COUNT), 48'h0ED8);
        chk(48'(O_LINK_CHANNEL_BASE_FREQUENCY), 48'h2FAF_0800);
        apb(1'b0, ds_cfg_pkg::OFS_STATUS, 32'h0000_0000);
        chk(48'(rd[9:0]), 48'h101);
        el(8'h06, 8'h02, 8'h06, 48'h0A1B_2C3D_4E5F);
        chk(O_OWNING_CORE_MAC, 48'h0A1B_2C3D_4E5F);
        apb(1'b0, ds_cfg_pkg::OFS_MAC_HI, 32'h0000_0000);
        chk(48'(rd), 48'h0A1B);
        apb(1'b1, ds_cfg_pkg::OFS_CTRL, 32'h0000_0002);
        chk(O_OWNING_CORE_MAC, 48'h0);
        clr;
    endtask
    task t_desc;
        core_u.send_desc(32'h1234_5678, 16'h0010, 16'h0100, 16'h00F1, 8'h02, 8'h03, 32'h3B9A_CA00);
        repeat (3) @(posedge I_CLK);
        chk(48'({O_LOWEST_ACTIVE_TONE, O_HIGHEST_ACTIVE_TONE}), 48'h0010_0100);
        chk(48'({O_BASE_TONE_FREQUENCY, O_ACTIVE_TONE_COUNT}), 48'h1234_5678_00F1);
        chk(48'({O_GUARD_PREFIX_LENGTH, O_WINDOW_TAPER_LENGTH}), 48'h2_0080);
        chk(48'(O_LINK_CHANNEL_BASE_FREQUENCY), 48'h3B9A_CA00);
        core_u.send_desc(32'h0, 16'h0222, 16'h0, 16'h0, 8'h00, 8'h01, 32'h0);
        repeat (3) @(posedge I_CLK);
        chk(48'(O_LOWEST_ACTIVE_TONE), 48'h0010);
        apb(1'b0, ds_cfg_pkg::OFS_STATUS, 32'h0000_0000);
        chk(48'(rd[9:0]), 48'h301);
        clr;
    endtask
    task t_bus;
        apb(1'b0, 12'h02C, 32'h0000_0000);
        chk(48'({er, rd}), 48'h1_0000_0000);
        apb(1'b1, ds_cfg_pkg::OFS_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, ds_cfg_pkg::OFS_STATUS, 32'h0000_0000);
        chk(48'({er, rd}), 48'h0);
    endtask
    // ===
    // main sequence
    initial begin
        repeat (20) @(posedge I_CLK);
        I_RST <= 1'b0;
        @(posedge I_CLK);
        chk(48'({O_CHANNEL_ADMIN_CONDITION, O_ERROR}), 48'h2);
        chk(O_OWNING_CORE_MAC, 48'h0);
        t_codes;
        t_flip;
        t_ofdm;
        t_desc;
        t_bus;
        end_of_test;
    end
endmodule
